//--- pic_top.sv
// prioritised interrupt controller with classic wishbone register slave
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module pic_top
   import pic_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   // wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [31:0] ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic [31:0]      DAT_O,
   output logic             ACK_O,
   // interrupt sources
   input  wire logic [31:0] PERIPH_REQ_I,
   input  wire logic [1:0]  EXT_PIN_I,
   // processor requests
   output logic             CPU_NORMAL_REQUEST_N_O,
   output logic             CPU_FAST_REQUEST_N_O
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return m;
   endfunction

   // most urgent level in service, LVL_NONE if idle
   function automatic logic [3:0] lowest_level(input logic [7:0] v);
      logic [3:0] r;
      r = LVL_NONE;
      for (int i = PIC_LEVELS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   pic_bus_state_t state;
   pic_bus_state_t next_state;
   logic [1:0]     scr_type [PIC_CHANNELS];
   logic [2:0]     scr_prio [PIC_CHANNELS];
   logic [3:0]     irqsc;
   logic [31:0]    mask;
   logic [7:0]     in_service;
   logic [7:0]     next_in_service;
   logic [1:0]     pin_meta;
   logic [1:0]     pin_sync;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire logic       req      = CYC_I & STB_I & (state == ST_IDLE);
   wire logic       wr       = req & WE_I;
   wire logic       rd       = req & ~WE_I;
   wire logic [7:0] idx      = ADR_I[9:2];
   wire logic [4:0] sel_ch   = idx[4:0];
   wire logic       hit_scr  = (idx <= IDX_SCR_LAST);
   wire logic       ch_used  = PIC_ASSIGNED[sel_ch];
   wire logic [31:0] wmask   = DAT_I & lane_mask(SEL_I);

   wire logic wr_scr   = wr & hit_scr & SEL_I[0] & ch_used;
   wire logic wr_irqsc = wr & (idx == IDX_IRQSC) & SEL_I[0];
   wire logic wr_mecr  = wr & (idx == IDX_MECR);
   wire logic wr_mdcr  = wr & (idx == IDX_MDCR);
   wire logic wr_eos   = wr & (idx == IDX_EOSCR);
   wire logic rd_isnr  = rd & (idx == IDX_ISNR);

   assign next_state = req ? ST_ACK : ST_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // sources

   logic [31:0] chan_raw;
   logic [31:0] chan_active;
   logic [1:0]  ext_active;
   logic [31:0] lvl_ok;
   logic [31:0] eligible;
   logic [31:0] take_ch;
   logic        take;
   logic        win_found;
   logic [3:0]  win_lvl;
   logic [4:0]  win_ch;
   logic [3:0]  cur_lvl;
   logic [7:0]  push_vec;
   logic [7:0]  pop_vec;

   wire logic take_ext = take_ch[CH_EXT_GROUP];

   // pin inputs are asynchronous; meta stage feeds the sync stage only
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
      end else begin
         pin_meta <= EXT_PIN_I;
         pin_sync <= pin_meta;
      end
   end

   for (genvar p = 0; p < EXT_PINS; p++) begin : g_pin
      pic_trig u_pin (
         .clk_i    (CLK_SYS_I),
         .rst_i    (RST_I),
         .level_i  (pin_sync[p]),
         .type_i   (irqsc[2*p+1:2*p]),
         .take_i   (take_ext),
         .active_o (ext_active[p])
      );
   end

   // peripheral lines are active-high levels; reserved channels read zero
   assign chan_raw = {PERIPH_REQ_I[31:3], |ext_active, PERIPH_REQ_I[1:0]}
                     & PIC_ASSIGNED;

   for (genvar ch = 0; ch < PIC_CHANNELS; ch++) begin : g_ch
      if (PIC_ASSIGNED[ch]) begin : g_used
         pic_trig u_trig (
            .clk_i    (CLK_SYS_I),
            .rst_i    (RST_I),
            .level_i  (chan_raw[ch]),
            .type_i   (scr_type[ch]),
            .take_i   (take_ch[ch]),
            .active_o (chan_active[ch])
         );
      end else begin : g_rsvd
         assign chan_active[ch] = 1'b0;
      end
      // only strictly more urgent than the level in service may pass
      assign lvl_ok[ch]  = ({1'b0, scr_prio[ch]} < cur_lvl);
      assign take_ch[ch] = take & (win_ch == 5'(ch));
   end

   assign eligible = chan_active & mask & lvl_ok;

   ////////////////////////////////////////////////////////////////////////
   // arbitration

   // strict compare keeps the first, lowest channel on a tie
   always_comb begin
      win_found = 1'b0;
      win_lvl   = LVL_NONE;
      win_ch    = 5'h00;
      for (int ch = 0; ch < PIC_CHANNELS; ch++) begin
         if (eligible[ch] && ({1'b0, scr_prio[ch]} < win_lvl)) begin
            win_found = 1'b1;
            win_lvl   = {1'b0, scr_prio[ch]};
            win_ch    = 5'(ch);
         end
      end
   end

   wire logic fast_act   = win_found & (win_lvl == 4'h0);
   wire logic normal_act = win_found & (win_lvl != 4'h0);

   // reading the source number is the acknowledge that starts service
   assign take     = rd_isnr & win_found;
   assign cur_lvl  = lowest_level(in_service);
   assign push_vec = take ? (8'h01 << win_lvl[2:0]) : 8'h00;
   assign pop_vec  = (wr_eos && cur_lvl != LVL_NONE) ?
                     (8'h01 << cur_lvl[2:0]) : 8'h00;
   // a level-0 winner still passes while a normal level is in service
   assign next_in_service = (in_service & ~pop_vec) | push_vec;

   ////////////////////////////////////////////////////////////////////////
   // read mux

   logic [31:0] rd_word;
   wire logic [31:0] scr_word = ch_used ?
      {24'h00_0000, scr_type[sel_ch], 3'h0, scr_prio[sel_ch]} : 32'h0000_0000;

   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_scr) begin
         rd_word = scr_word;
      end else begin
         unique case (idx)
            IDX_IRQSC: rd_word = {28'h000_0000, irqsc};
            IDX_IRSR:  rd_word = chan_raw;
            IDX_IASR:  rd_word = chan_active;
            IDX_ISR:   rd_word = chan_active & mask;
            IDX_IPER:  rd_word = {25'h000_0000, win_ch, 2'h0};
            IDX_ISNR:  rd_word = {27'h000_0000, win_ch};
            IDX_IMR:   rd_word = mask;
            IDX_OISR:  rd_word = {30'h0000_0000, normal_act, fast_act};
            default:   rd_word = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         state <= ST_IDLE;
         ACK_O <= 1'b0;
         DAT_O <= 32'h0000_0000;
      end else begin
         state <= next_state;
         ACK_O <= req;
         DAT_O <= rd ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         for (int ch = 0; ch < PIC_CHANNELS; ch++) begin
            scr_type[ch] <= SCR_TYPE_RST;
            scr_prio[ch] <= SCR_PRIO_RST;
         end
      end else if (wr_scr) begin
         scr_type[sel_ch] <= DAT_I[SCR_TYPE_LSB +: 2];
         scr_prio[sel_ch] <= DAT_I[SCR_PRIO_LSB +: 3];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         irqsc      <= IRQSC_RESET;
         mask       <= MASK_RESET;
         in_service <= INSVC_RESET;
      end else begin
         if (wr_irqsc) begin
            irqsc <= DAT_I[3:0];
         end
         if (wr_mecr) begin
            mask <= (mask | wmask) & PIC_ASSIGNED;
         end else if (wr_mdcr) begin
            mask <= mask & ~wmask;
         end
         in_service <= next_in_service;
      end
   end

   // outputs straight from flops, active low
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         CPU_FAST_REQUEST_N_O   <= 1'b1;
         CPU_NORMAL_REQUEST_N_O <= 1'b1;
      end else begin
         CPU_FAST_REQUEST_N_O   <= ~fast_act;
         CPU_NORMAL_REQUEST_N_O <= ~normal_act;
      end
   end

endmodule
`default_nettype wire

//--- pic_pkg.sv
// constants and types shared by the prioritised interrupt controller
package pic_pkg;

   localparam int          PIC_CHANNELS  = 32;
   localparam int          PIC_LEVELS    = 8;
   // channels that carry a source: 2, 3, 7 and 12..21
   localparam logic [31:0] PIC_ASSIGNED  = 32'h003F_F08C;
   localparam logic [4:0]  CH_EXT_GROUP  = 5'h02;
   localparam int          EXT_PINS      = 2;

   // trigger type encoding
   localparam logic [1:0]  TRIG_LOW      = 2'h0;
   localparam logic [1:0]  TRIG_HIGH     = 2'h1;
   localparam logic [1:0]  TRIG_FALL     = 2'h2;
   localparam logic [1:0]  TRIG_RISE     = 2'h3;

   // source control word layout and reset value
   localparam int          SCR_TYPE_LSB  = 6;
   localparam int          SCR_PRIO_LSB  = 0;
   localparam logic [31:0] SCR_RESET     = 32'h0000_0047;
   localparam logic [1:0]  SCR_TYPE_RST  = SCR_RESET[7:6];
   localparam logic [2:0]  SCR_PRIO_RST  = SCR_RESET[2:0];

   // other reset values
   localparam logic [3:0]  IRQSC_RESET   = 4'h0;
   localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
   localparam logic [7:0]  INSVC_RESET   = 8'h00;
   localparam logic [3:0]  LVL_NONE      = 4'h8;

   // word indices (byte offset / 4)
   localparam logic [7:0]  IDX_SCR_LAST  = 8'h1F;
   localparam logic [7:0]  IDX_IRQSC     = 8'h20;
   localparam logic [7:0]  IDX_IRSR      = 8'h40;
   localparam logic [7:0]  IDX_IASR      = 8'h41;
   localparam logic [7:0]  IDX_ISR       = 8'h42;
   localparam logic [7:0]  IDX_IPER      = 8'h43;
   localparam logic [7:0]  IDX_ISNR      = 8'h44;
   localparam logic [7:0]  IDX_IMR       = 8'h45;
   localparam logic [7:0]  IDX_OISR      = 8'h46;
   localparam logic [7:0]  IDX_MECR      = 8'h48;
   localparam logic [7:0]  IDX_MDCR      = 8'h49;
   localparam logic [7:0]  IDX_EOSCR     = 8'h4C;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK  = 2'b10
   } pic_bus_state_t;

endpackage

//--- pic_trig.sv
// per-source trigger qualifier: level or edge, either polarity
`timescale 1ns/10ps
`default_nettype none
module pic_trig
   import pic_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // source and setup
   input  wire logic       level_i,
   input  wire logic [1:0] type_i,
   input  wire logic       take_i,
   // qualified request
   output logic            active_o
);

   logic prev;
   logic pend;
   logic next_pend;

   wire logic rise     = level_i & ~prev;
   wire logic fall     = ~level_i & prev;
   wire logic is_edge  = type_i[1];
   wire logic edge_hit = (type_i == TRIG_RISE) ? rise : fall;

   // edge pending self-clears on take; a new edge in that cycle wins
   assign next_pend = is_edge & (edge_hit | (pend & ~take_i));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= 1'b0;
         pend <= 1'b0;
      end else begin
         prev <= level_i;
         pend <= next_pend;
      end
   end

   // level modes follow the input and are never cleared here
   assign active_o = is_edge ? pend :
                     ((type_i == TRIG_HIGH) ? level_i : ~level_i);

endmodule
`default_nettype wire

//--- pic_top_checker.sv
// port-level assertions for the prioritised interrupt controller
`timescale 1ns/10ps
`default_nettype none
module pic_top_checker
   import pic_pkg::*;
(
   // clock, reset and bus
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [31:0] ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   input  wire logic [31:0] DAT_O,
   input  wire logic        ACK_O,
   // processor requests
   input  wire logic        CPU_NORMAL_REQUEST_N_O,
   input  wire logic        CPU_FAST_REQUEST_N_O
);
   ////////////////////////////////////////////////////////////////////////
   logic armed;
   wire  mask_wr = ACK_O && WE_I && ADR_I[9:2] == IDX_MECR;
   // nothing can be unmasked before the first mask-set write
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) armed <= 1'b0;
      else if (mask_wr) armed <= 1'b1;
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   ////////////////////////////////////////////////////////////////////////
   ack_pulse_a: assert property (ACK_O |=> !ACK_O)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("request not answered next cycle");
   ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I))
      else $error("ack without request");
   dat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
      else $error("read data outside ack");
   one_winner_a: assert property (
      CPU_NORMAL_REQUEST_N_O || CPU_FAST_REQUEST_N_O)
      else $error("both requests active");
   reset_quiet_a: assert property ($past(RST_I) |->
      CPU_NORMAL_REQUEST_N_O && CPU_FAST_REQUEST_N_O)
      else $error("request active right after reset");
   mask_gate_a: assert property (!armed |->
      CPU_NORMAL_REQUEST_N_O && CPU_FAST_REQUEST_N_O)
      else $error("request while all sources masked");
   clear_all_a: assert property (ACK_O && WE_I && ADR_I[9:2] == IDX_MDCR
      && DAT_I == 32'hFFFF_FFFF && SEL_I == 4'hF
      |=> CPU_NORMAL_REQUEST_N_O && CPU_FAST_REQUEST_N_O)
      else $error("request survives mask clear");
endmodule
`default_nettype wire

//--- pic_src_model.sv
// peripheral request lines and external pins as seen by the controller
`timescale 1ns/10ps
`default_nettype none
module pic_src_model (
   // clock
   input  wire logic        clk_i,
   // wanted levels
   input  wire logic [31:0] want_req_i,
   input  wire logic [1:0]  want_pin_i,
   // driven lines
   output logic [31:0]      req_o,
   output logic [1:0]       pin_o
);
   // one source per line, active-high levels from peripherals
   always_ff @(posedge clk_i) begin
      req_o <= want_req_i;
      pin_o <= want_pin_i;
   end
endmodule
`default_nettype wire

//--- prioritized_interrupt_controller_tb_top.sv
// self-checking bench for the prioritised interrupt controller
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_controller_tb_top;
   import pic_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [31:0] adr = '0, dat = '0, dat_o, req, want = '0, q, rs = 32'h19ca;
   logic [3:0]  sel = '0;
   logic [1:0]  pin, pins = '0;
   logic        ack, nrm_n, fst_n;
   logic [2:0]  p;
   int          fail_count = 0, checked = 0;
   always #2 clk = ~clk;
   pic_top u_dut (.CLK_SYS_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
      .ACK_O(ack), .PERIPH_REQ_I(req), .EXT_PIN_I(pin),
      .CPU_NORMAL_REQUEST_N_O(nrm_n), .CPU_FAST_REQUEST_N_O(fst_n));
   pic_src_model u_src (.clk_i(clk), .want_req_i(want), .want_pin_i(pins),
      .req_o(req), .pin_o(pin));
   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // source driven 0 -> 1 -> 0, edge pendings never taken
   function logic exp_act(input logic [1:0] t, input logic lvl);
      if (!t[1]) return lvl ^ !t[0];
      return t == TRIG_RISE || !lvl;
   endfunction
   task summarize;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // classic single cycle; waits for ack, bounded
   task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {22'h0, a}; dat <= d;
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_o;
      if (n >= 50) fail_count++;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task rd(input logic [9:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask
   task outs(input logic [1:0] e);
      repeat (8) @(posedge clk);
      chk("outputs", {30'h0, e}, {30'h0, nrm_n, fst_n});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #40000;
      fail_count++;
      summarize;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(10'h030, SCR_RESET, "scr12");
      rd(10'h010, 32'h0000_0000, "scr4");
      rd(10'h3FC, 32'h0000_0000, "unmapped");
      $display("test reset done");
      wb(1'b1, 10'h120, 32'h0000_3000);
      wb(1'b1, 10'h030, 32'h0000_0043);
      wb(1'b1, 10'h034, 32'h0000_0040);
      want <= (rs & ~PIC_ASSIGNED & ~32'h0000_0004) | 32'h0000_1000;
      outs(2'b01);
      // pins idle low in low-level mode, so channel 2 reads raw active
      rd(10'h100, 32'h0000_1004, "raw");
      rd(10'h110, 32'h0000_000C, "normal winner");
      outs(2'b11);
      want <= 32'h0000_3000;
      outs(2'b10);
      rd(10'h110, 32'h0000_000D, "fast winner");
      wb(1'b1, 10'h130, 32'h0000_0000);
      wb(1'b1, 10'h130, 32'h0000_0000);
      wb(1'b1, 10'h124, 32'hFFFF_FFFF);
      outs(2'b11);
      $display("test nesting done");
      rs = lfsr(rs);
      p = (rs[2:0] == 3'h0) ? 3'h1 : rs[2:0];
      wb(1'b1, 10'h038, {24'h0, 5'h08, p});
      wb(1'b1, 10'h03C, {24'h0, 5'h08, p});
      wb(1'b1, 10'h120, 32'h0000_C000);
      want <= 32'h0000_C000;
      outs(2'b01);
      rd(10'h110, 32'h0000_000E, "tie");
      wb(1'b1, 10'h130, 32'h0000_0000);
      wb(1'b1, 10'h124, 32'hFFFF_FFFF);
      wb(1'b1, 10'h120, 32'h0001_0000);
      $display("test tie done");
      for (int t = 0; t < 4; t++) begin
         want <= 32'h0000_0000;
         wb(1'b1, 10'h040, 32'h0000_0041);
         wb(1'b1, 10'h040, {24'h0, 2'(t), 6'h01});
         for (int k = 0; k < 2; k++) begin
            want <= {15'h0, !k[0], 16'h0};
            repeat (4) @(posedge clk);
            rd(10'h104, {15'h0, exp_act(2'(t), !k[0]), 13'h0, 3'h4},
               "type");
         end
      end
      rd(10'h110, 32'h0000_0010, "edge winner");
      rd(10'h104, 32'h0000_0004, "edge taken");
      wb(1'b1, 10'h130, 32'h0000_0000);
      wb(1'b1, 10'h124, 32'hFFFF_FFFF);
      $display("test trigger done");
      wb(1'b1, 10'h008, 32'h0000_0042);
      wb(1'b1, 10'h080, 32'h0000_000D);
      wb(1'b1, 10'h120, 32'h0000_0004);
      pins <= 2'b01;
      outs(2'b01);
      pins <= 2'b00;
      outs(2'b11);
      pins <= 2'b10;
      outs(2'b01);
      pins <= 2'b00;
      outs(2'b01);
      rd(10'h110, 32'h0000_0002, "pin winner");
      outs(2'b11);
      $display("test pins done");
      summarize;
   end
endmodule
bind pic_top pic_top_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
   .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
   .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .CPU_NORMAL_REQUEST_N_O(CPU_NORMAL_REQUEST_N_O),
   .CPU_FAST_REQUEST_N_O(CPU_FAST_REQUEST_N_O));
`default_nettype wire
